// [pmbsm_core.sv]
// Module: PMBus restore, alert mask, format, rail power-good timing and fan status block
//
// Behaviour
// R1: Restore-defaults command 12h copies default store into working parameters.
// R2: Never-written default store means restore loads built-in fixed values.
// R3: Alert mask command 1Bh blocks chosen status bits from the alert line.
// R4: Mask access needs a valid status selector; unknown selectors are refused.
// R5: Each mask access moves exactly one mask byte for the chosen status byte.
// R6: Maker status word masked bytewise; index n covers bits 8n+7..8n, indices 0-5; the word is 40 bits here, so index 5 covers none.
// R7: Output-voltage format mode field is read-only and always reads 000b.
// R8: Five-bit exponent field of format byte is writable and signed.
// R9: Host writes the exponent before any linear16 voltage value.
// R10: Current-sense gain is held as a resistance in milliohms.
// R11: Retired fault-response commands 41h,45h,47h,4Ch,50h,63h are refused.
// R12: Turn-on limit bounds milliseconds from enable to power-good.
// R13: Unmonitored rail becomes power-good after the turn-on limit elapses.
// R14: Unmonitored rail drops power-good after the turn-off limit elapses.
// R15: Turn-off limit 7FFFh drops unmonitored power-good at once on disable.
// R16: Single-byte maker status command 80h is refused; wide word used instead.
// R17: Fan fault sets after speed below limit for five consecutive seconds.
// R18: Up to four fans: only bits 7 and 6 of each fan byte used.
// R19: More than four fans: faults 1-8 and 9-16 fill bits 0-7.
// R20: Unsupported fan bits read zero and never raise the alert.
`timescale 1ns/1ps
module pmbsm_core #(
   parameter int NUM_FANS         = 4,
   parameter int MS_CYCLES        = pmbsm_pkg::MS_CYCLES,
   parameter int FAN_FAULT_CYCLES = pmbsm_pkg::FAN_FAULT_CYCLES
) (
   input  wire logic                          CLK_IN,
   input  wire logic                          RST_IN,
   input  wire logic                          LINK_CLK_IN,
   input  wire logic                          LNK_REQ_IN,
   input  wire pmbsm_pkg::pmbsm_cmd_t         LNK_CMD_IN,
   output logic                               LNK_BUSY_OUT,
   output logic                               LNK_DONE_OUT,
   output pmbsm_pkg::pmbsm_rsp_t              LNK_RSP_OUT,
   input  wire pmbsm_pkg::pmbsm_std_stat_t    STD_STATUS_IN,
   input  wire logic [pmbsm_pkg::MFR_STAT_W-1:0] MFR_STATUS_IN,
   input  wire logic                          RAIL_EN_IN,
   input  wire logic                          RAIL_MON_PRESENT_IN,
   input  wire logic                          RAIL_MON_PG_IN,
   output logic                               RAIL_PG_OUT,
   input  wire logic [NUM_FANS-1:0]           FAN_SLOW_IN,
   output logic                               ALERT_OUT,
   output logic                               ALERT_OE_OUT
);
   // ************************************
   // Declarations
   // ************************************
   pmbsm_pkg::pmbsm_cmd_t   lnk_cmd_q;
   pmbsm_pkg::pmbsm_rsp_t   rsp_q;
   pmbsm_pkg::pmbsm_rsp_t   lnk_rsp_q;
   pmbsm_pkg::pmbsm_param_t work_q;
   pmbsm_pkg::pmbsm_param_t nv_q;
   pmbsm_pkg::pmbsm_pg_t    pg_st_q;
   logic                    nv_valid_q;
   logic                    req_tog_q, rq_s1_q, rq_s2_q, rq_s3_q;
   logic                    ack_tog_q, ak_s1_q, ak_s2_q, ak_s3_q;
   logic                    lrst_s1_q, lrst_q;
   logic                    exec;
   logic [4:0]              sel_info;
   logic                    en_s1_q, en_q, en_d1_q;
   logic                    mon_s1_q, mon_q, mpg_s1_q, mpg_q;
   logic [NUM_FANS-1:0]     slow_s1_q, slow_q, fault_q;
   logic [31:0]             fan_cnt_q [NUM_FANS];
   logic [31:0]             ms_pre_q;
   logic [15:0]             ms_cnt_q;
   logic                    ms_tick;
   logic                    pg_q;
   logic [7:0]              fan_first, fan_second;
   logic [pmbsm_pkg::MASK_BYTES*8-1:0] stat_vec;
   logic                    alert_q;

   // ************************************
   // Functions
   // ************************************
   // Map a status selector to {valid, mask byte index}
   function automatic logic [4:0] sel_index(input logic [7:0] sel);
      logic [7:0] off;
      off = sel - pmbsm_pkg::SEL_MFR_BASE;
      unique case (sel)
         pmbsm_pkg::SEL_VOUT:       sel_index = 5'h10;
         pmbsm_pkg::SEL_IOUT:       sel_index = 5'h11;
         pmbsm_pkg::SEL_TEMP:       sel_index = 5'h12;
         pmbsm_pkg::SEL_CML:        sel_index = 5'h13;
         pmbsm_pkg::CMD_FAN_FIRST:  sel_index = 5'h14;
         pmbsm_pkg::CMD_FAN_SECOND: sel_index = 5'h15;
         default: begin
            if (off < {4'h0, pmbsm_pkg::MFR_SUB_CNT}) begin
               sel_index = {1'b1, off[3:0] + pmbsm_pkg::IDX_MFR_BASE}; // R6
            end else begin
               sel_index = 5'h00;
            end
         end
      endcase
   endfunction

   // Commands this block refuses outright
   function automatic logic is_retired(input logic [7:0] code);
      is_retired = (code == pmbsm_pkg::CMD_RET_VOV) || (code == pmbsm_pkg::CMD_RET_VUV) ||
                   (code == pmbsm_pkg::CMD_RET_IOC) || (code == pmbsm_pkg::CMD_RET_IUC) ||
                   (code == pmbsm_pkg::CMD_RET_OT)  || (code == pmbsm_pkg::CMD_RET_TON) ||
                   (code == pmbsm_pkg::CMD_MFR_BYTE);
   endfunction

   // ************************************
   // Link domain
   // ************************************
   // Reset brought into the link clock domain
   always_ff @(posedge LINK_CLK_IN) begin
      lrst_s1_q <= RST_IN;
      lrst_q    <= lrst_s1_q;
   end

   // Capture a request and flip the request toggle; held until the answer returns
   always_ff @(posedge LINK_CLK_IN) begin
      if (lrst_q) begin
         req_tog_q <= 1'b0;
         lnk_cmd_q <= '0;
      end else if (LNK_REQ_IN && !LNK_BUSY_OUT) begin
         req_tog_q <= ~req_tog_q;
         lnk_cmd_q <= LNK_CMD_IN;
      end
   end

   // Answer toggle synchroniser and answer capture
   always_ff @(posedge LINK_CLK_IN) begin
      if (lrst_q) begin
         ak_s1_q   <= 1'b0;
         ak_s2_q   <= 1'b0;
         ak_s3_q   <= 1'b0;
         lnk_rsp_q <= '0;
      end else begin
         ak_s1_q <= ack_tog_q;
         ak_s2_q <= ak_s1_q;
         ak_s3_q <= ak_s2_q;
         if (ak_s2_q != ak_s3_q) begin
            lnk_rsp_q <= rsp_q;
         end
      end
   end

   // Link handshake outputs
   assign LNK_BUSY_OUT = (req_tog_q != ak_s3_q);
   assign LNK_DONE_OUT = (ak_s2_q != ak_s3_q);
   assign LNK_RSP_OUT  = lnk_rsp_q;

   // ************************************
   // Crossing into the core domain
   // ************************************
   // Request toggle and pin synchronisers
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         {rq_s1_q, rq_s2_q, rq_s3_q} <= 3'h0;
         {en_s1_q, en_q, en_d1_q}    <= 3'h0;
         {mon_s1_q, mon_q}           <= 2'h0;
         {mpg_s1_q, mpg_q}           <= 2'h0;
         slow_s1_q                   <= '0;
         slow_q                      <= '0;
      end else begin
         rq_s1_q   <= req_tog_q;
         rq_s2_q   <= rq_s1_q;
         rq_s3_q   <= rq_s2_q;
         en_s1_q   <= RAIL_EN_IN;
         en_q      <= en_s1_q;
         en_d1_q   <= en_q;
         mon_s1_q  <= RAIL_MON_PRESENT_IN;
         mon_q     <= mon_s1_q;
         mpg_s1_q  <= RAIL_MON_PG_IN;
         mpg_q     <= mpg_s1_q;
         slow_s1_q <= FAN_SLOW_IN;
         slow_q    <= slow_s1_q;
      end
   end

   // One-cycle execute strobe per request; command fields are stable by then
   assign exec     = (rq_s2_q != rq_s3_q);
   assign sel_info = sel_index(lnk_cmd_q.sel);

   // ************************************
   // Command execution
   // ************************************
   // Working parameters: restore, mask and field writes
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         work_q <= pmbsm_pkg::DEF_PARAM;
      end else if (exec && lnk_cmd_q.wr) begin
         unique case (lnk_cmd_q.code)
            pmbsm_pkg::CMD_RESTORE: begin
               work_q <= nv_valid_q ? nv_q : pmbsm_pkg::DEF_PARAM; // R1 R2
            end
            pmbsm_pkg::CMD_ALERT_MASK: begin
               if (sel_info[4]) begin
                  work_q.masks[8*sel_info[3:0] +: 8] <= lnk_cmd_q.data[7:0]; // R3 R5
               end
            end
            pmbsm_pkg::CMD_VOUT_FMT:  work_q.vout_exp       <= lnk_cmd_q.data[4:0]; // R8 R9
            pmbsm_pkg::CMD_IOUT_GAIN: work_q.iout_gain_mohm <= lnk_cmd_q.data; // R10
            pmbsm_pkg::CMD_TON_MAX:   work_q.ton_max_ms     <= lnk_cmd_q.data; // R12
            pmbsm_pkg::CMD_TOFF_MAX:  work_q.toff_max_ms    <= lnk_cmd_q.data; // R14
            default: ;
         endcase
      end
   end

   // Default store: saved from working parameters, remembers whether it was written
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         nv_q       <= pmbsm_pkg::DEF_PARAM;
         nv_valid_q <= 1'b0;
      end else if (exec && lnk_cmd_q.wr && lnk_cmd_q.code == pmbsm_pkg::CMD_STORE_DEF) begin
         nv_q       <= work_q;
         nv_valid_q <= 1'b1;
      end
   end

   // Answer word and answer toggle
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         rsp_q     <= '0;
         ack_tog_q <= 1'b0;
      end else if (exec) begin
         ack_tog_q     <= ~ack_tog_q;
         rsp_q.nack    <= 1'b0;
         rsp_q.data    <= '0;
         if (is_retired(lnk_cmd_q.code)) begin
            rsp_q.nack <= 1'b1; // R11 R16
         end else begin
            unique case (lnk_cmd_q.code)
               pmbsm_pkg::CMD_RESTORE, pmbsm_pkg::CMD_STORE_DEF: rsp_q.nack <= !lnk_cmd_q.wr;
               pmbsm_pkg::CMD_ALERT_MASK: begin
                  rsp_q.nack <= !sel_info[4]; // R4
                  if (!lnk_cmd_q.wr && sel_info[4]) begin
                     rsp_q.data[7:0] <= work_q.masks[8*sel_info[3:0] +: 8]; // R5
                  end
               end
               pmbsm_pkg::CMD_VOUT_FMT: begin
                  if (!lnk_cmd_q.wr) begin
                     rsp_q.data[7:0] <= {pmbsm_pkg::OUTPUT_VOLTAGE_FORMAT_LINEAR, work_q.vout_exp}; // R7
                  end
               end
               pmbsm_pkg::CMD_IOUT_GAIN: if (!lnk_cmd_q.wr) rsp_q.data <= work_q.iout_gain_mohm;
               pmbsm_pkg::CMD_TON_MAX:   if (!lnk_cmd_q.wr) rsp_q.data <= work_q.ton_max_ms;
               pmbsm_pkg::CMD_TOFF_MAX:  if (!lnk_cmd_q.wr) rsp_q.data <= work_q.toff_max_ms;
               pmbsm_pkg::CMD_FAN_FIRST: begin
                  rsp_q.nack      <= lnk_cmd_q.wr;
                  rsp_q.data[7:0] <= fan_first;
               end
               pmbsm_pkg::CMD_FAN_SECOND: begin
                  rsp_q.nack      <= lnk_cmd_q.wr;
                  rsp_q.data[7:0] <= fan_second;
               end
               default: rsp_q.nack <= 1'b1;
            endcase
         end
      end
   end

   // ************************************
   // Rail power-good timing
   // ************************************
   // Millisecond tick, restarted on each change of the synchronised enable
   assign ms_tick = (ms_pre_q == 32'(MS_CYCLES - 1));

   always_ff @(posedge CLK_IN) begin
      if (RST_IN || en_q != en_d1_q) begin
         ms_pre_q <= '0;
         ms_cnt_q <= '0;
      end else if (ms_tick) begin
         ms_pre_q <= '0;
         ms_cnt_q <= ms_cnt_q + 16'h0001;
      end else begin
         ms_pre_q <= ms_pre_q + 32'h1;
      end
   end

   // Power-good state for a rail without a monitor pin
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         pg_st_q <= pmbsm_pkg::PG_OFF;
      end else if (en_q && !en_d1_q) begin
         pg_st_q <= pmbsm_pkg::PG_RISE;
      end else if (!en_q && en_d1_q) begin
         if (work_q.toff_max_ms == pmbsm_pkg::TOFF_NO_LIMIT) begin
            pg_st_q <= pmbsm_pkg::PG_OFF; // R15
         end else begin
            pg_st_q <= pmbsm_pkg::PG_FALL;
         end
      end else begin
         unique case (pg_st_q)
            pmbsm_pkg::PG_RISE: if (ms_cnt_q >= work_q.ton_max_ms) pg_st_q <= pmbsm_pkg::PG_ON; // R13
            pmbsm_pkg::PG_FALL: if (ms_cnt_q >= work_q.toff_max_ms) pg_st_q <= pmbsm_pkg::PG_OFF; // R14
            pmbsm_pkg::PG_OFF, pmbsm_pkg::PG_ON: ;
         endcase
      end
   end

   // Power-good output: monitor pin gated by the enable when present, else the timed state
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         pg_q <= 1'b0;
      end else if (mon_q) begin
         pg_q <= mpg_q && en_q;
      end else begin
         pg_q <= (pg_st_q == pmbsm_pkg::PG_ON) || (pg_st_q == pmbsm_pkg::PG_FALL); // R12
      end
   end
   assign RAIL_PG_OUT = pg_q;

   // ************************************
   // Fan fault qualification
   // ************************************
   // Per-fan timer; fault once slow for the full qualification time
   always_ff @(posedge CLK_IN) begin
      for (int i = 0; i < NUM_FANS; i++) begin
         if (RST_IN || !slow_q[i]) begin
            fan_cnt_q[i] <= '0;
            fault_q[i]   <= 1'b0;
         end else if (fan_cnt_q[i] == 32'(FAN_FAULT_CYCLES - 1)) begin
            fault_q[i]   <= 1'b1; // R17
         end else begin
            fan_cnt_q[i] <= fan_cnt_q[i] + 32'h1;
         end
      end
   end

   // Fan status byte packing
   always_comb begin
      fan_first  = '0;
      fan_second = '0;
      if (NUM_FANS > 4) begin
         for (int i = 0; i < NUM_FANS && i < 8; i++) fan_first[i] = fault_q[i]; // R19
         for (int i = 8; i < NUM_FANS && i < 16; i++) fan_second[i-8] = fault_q[i]; // R19
      end else begin
         if (NUM_FANS > 0) fan_first[7]  = fault_q[0]; // R18
         if (NUM_FANS > 1) fan_first[6]  = fault_q[1]; // R18
         if (NUM_FANS > 2) fan_second[7] = fault_q[2]; // R18
         if (NUM_FANS > 3) fan_second[6] = fault_q[3]; // R18 R20
      end
   end

   // ************************************
   // Alert line
   // ************************************
   // Status bytes in mask byte order; maker byte 5 has no status bits behind it
   assign stat_vec = {8'h00, MFR_STATUS_IN, fan_second, fan_first, STD_STATUS_IN.cml, STD_STATUS_IN.temp,
                      STD_STATUS_IN.iout, STD_STATUS_IN.vout};

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         alert_q <= 1'b0;
      end else begin
         alert_q <= |(stat_vec & ~work_q.masks); // R3 R6 R20
      end
   end
   assign ALERT_OUT    = 1'b0;
   assign ALERT_OE_OUT = alert_q;

   // ************************************
   // Assertions
   // ************************************
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);

   mask_block_a: assert property ((stat_vec & ~work_q.masks) == '0 |=> !ALERT_OE_OUT) // R3
      else $error("masked status drove the alert");
   restore_load_a: assert property (exec && lnk_cmd_q.wr && lnk_cmd_q.code == pmbsm_pkg::CMD_RESTORE // R1
      && nv_valid_q |=> work_q == $past(nv_q)) else $error("restore did not load default store");
   restore_fixed_a: assert property (exec && lnk_cmd_q.wr && lnk_cmd_q.code == pmbsm_pkg::CMD_RESTORE // R2
      && !nv_valid_q |=> work_q == pmbsm_pkg::DEF_PARAM) else $error("restore did not load fixed values");
   mode_zero_a: assert property (exec && !lnk_cmd_q.wr && lnk_cmd_q.code == pmbsm_pkg::CMD_VOUT_FMT // R7
      |=> rsp_q.data[7:5] == pmbsm_pkg::OUTPUT_VOLTAGE_FORMAT_LINEAR && rsp_q.data[4:0] == $past(work_q.vout_exp))
      else $error("format byte mode field not zero");
   retired_nack_a: assert property (exec && is_retired(lnk_cmd_q.code) |=> rsp_q.nack) // R11
      else $error("retired command not refused");
   mask_sel_a: assert property (exec && lnk_cmd_q.code == pmbsm_pkg::CMD_ALERT_MASK // R4
      |=> rsp_q.nack == !$past(sel_info[4])) else $error("mask selector check wrong");
   pg_rise_a: assert property (pg_st_q == pmbsm_pkg::PG_RISE && !mon_q && en_q && en_d1_q // R13
      && ms_cnt_q >= work_q.ton_max_ms |=> ##1 RAIL_PG_OUT) else $error("power-good late after turn-on");
   toff_imm_a: assert property (!en_q && en_d1_q && !mon_q // R15
      && work_q.toff_max_ms == pmbsm_pkg::TOFF_NO_LIMIT |=> ##1 !RAIL_PG_OUT) else $error("power-good held");
   fan_fault_a: assert property (slow_q[0] && fan_cnt_q[0] == 32'(FAN_FAULT_CYCLES - 1) |=> fault_q[0]) // R17
      else $error("fan fault not set after qualification");
   fan_early_a: assert property ($rose(fault_q[0]) |-> $past(fan_cnt_q[0]) == 32'(FAN_FAULT_CYCLES - 1)) // R17
      else $error("fan fault set early");
   fan_bits_a: assert property (NUM_FANS <= 4 |-> fan_first[5:0] == '0 && fan_second[5:0] == '0) // R18
      else $error("unsupported fan bit set");
   exec_answer_a: assert property (exec |=> $changed(ack_tog_q)) // R5
      else $error("request without answer");

   restore_c: cover property (exec && lnk_cmd_q.code == pmbsm_pkg::CMD_RESTORE && nv_valid_q);
   mask_wr_c: cover property (exec && lnk_cmd_q.wr && lnk_cmd_q.code == pmbsm_pkg::CMD_ALERT_MASK);
   pg_rise_c: cover property (!mon_q && $rose(RAIL_PG_OUT));
   fan_fault_c: cover property ($rose(fault_q[0]));
endmodule

// [pmbsm_pkg.sv]
// Package: command codes, defaults, timing constants and carrier types for the PMBus status/mask block
package pmbsm_pkg;
   // ************************************
   // Timing
   // ************************************
   localparam int CLK_HZ           = 50_000_000;
   localparam int MS_PER_S         = 1000;
   localparam int TICK_TIME_MS     = 1;
   localparam int MS_CYCLES        = CLK_HZ / MS_PER_S * TICK_TIME_MS;
   localparam int FAN_FAULT_TIME_S = 5;
   localparam int FAN_FAULT_CYCLES = CLK_HZ * FAN_FAULT_TIME_S;

   // ************************************
   // Command codes
   // ************************************
   localparam logic [7:0] CMD_STORE_DEF  = 8'h11;
   localparam logic [7:0] CMD_RESTORE    = 8'h12;
   localparam logic [7:0] CMD_ALERT_MASK = 8'h1b;
   localparam logic [7:0] CMD_VOUT_FMT   = 8'h20;
   localparam logic [7:0] CMD_IOUT_GAIN  = 8'h38;
   localparam logic [7:0] CMD_TON_MAX    = 8'h62;
   localparam logic [7:0] CMD_TOFF_MAX   = 8'h66;
   localparam logic [7:0] CMD_MFR_BYTE   = 8'h80;
   localparam logic [7:0] CMD_FAN_FIRST  = 8'h81;
   localparam logic [7:0] CMD_FAN_SECOND = 8'h82;
   localparam logic [7:0] CMD_RET_VOV    = 8'h41;
   localparam logic [7:0] CMD_RET_VUV    = 8'h45;
   localparam logic [7:0] CMD_RET_IOC    = 8'h47;
   localparam logic [7:0] CMD_RET_IUC    = 8'h4c;
   localparam logic [7:0] CMD_RET_OT     = 8'h50;
   localparam logic [7:0] CMD_RET_TON    = 8'h63;

   // ************************************
   // Alert mask selectors and layout
   // ************************************
   localparam logic [7:0] SEL_VOUT     = 8'h7a;
   localparam logic [7:0] SEL_IOUT     = 8'h7b;
   localparam logic [7:0] SEL_TEMP     = 8'h7d;
   localparam logic [7:0] SEL_CML      = 8'h7e;
   localparam logic [7:0] SEL_MFR_BASE = 8'he0;
   localparam logic [3:0] IDX_MFR_BASE = 4'h6;
   localparam logic [3:0] MFR_SUB_CNT  = 4'h6;
   localparam int         MASK_BYTES   = 12;
   localparam int         MFR_STAT_W   = 40;

   // ************************************
   // Field values and defaults
   // ************************************
   localparam logic [2:0]  OUTPUT_VOLTAGE_FORMAT_LINEAR = 3'h0;
   localparam logic [15:0] TOFF_NO_LIMIT    = 16'h7fff;
   localparam logic [4:0]  DEF_VOUT_EXP     = 5'h14;
   localparam logic [15:0] DEF_IOUT_GAIN    = 16'h0000;
   localparam logic [15:0] DEF_TON_MAX      = 16'h0064;
   localparam logic [15:0] DEF_TOFF_MAX     = 16'h7fff;

   // ************************************
   // Carrier types
   // ************************************
   typedef struct packed {
      logic [4:0]              vout_exp;
      logic [15:0]             iout_gain_mohm;
      logic [15:0]             ton_max_ms;
      logic [15:0]             toff_max_ms;
      logic [MASK_BYTES*8-1:0] masks;
   } pmbsm_param_t;

   typedef struct packed {
      logic        wr;
      logic [7:0]  code;
      logic [7:0]  sel;
      logic [15:0] data;
   } pmbsm_cmd_t;

   typedef struct packed {
      logic        nack;
      logic [15:0] data;
   } pmbsm_rsp_t;

   typedef struct packed {
      logic [7:0] vout;
      logic [7:0] iout;
      logic [7:0] temp;
      logic [7:0] cml;
   } pmbsm_std_stat_t;

   typedef enum logic [1:0] {PG_OFF, PG_RISE, PG_ON, PG_FALL} pmbsm_pg_t;

   localparam pmbsm_param_t DEF_PARAM = '{vout_exp: DEF_VOUT_EXP, iout_gain_mohm: DEF_IOUT_GAIN,
                                          ton_max_ms: DEF_TON_MAX, toff_max_ms: DEF_TOFF_MAX, masks: '0};
endpackage

// [pmbsm_host.sv]
// Host model that issues one link request at a time and collects the answer
`timescale 1ns/1ps
module pmbsm_host (
   input  wire logic                  LINK_CLK_IN,
   input  wire logic                  BUSY_IN,
   input  wire logic                  DONE_IN,
   input  wire pmbsm_pkg::pmbsm_rsp_t RSP_IN,
   output logic                       REQ_OUT,
   output pmbsm_pkg::pmbsm_cmd_t      CMD_OUT
);
   logic timed_out = 1'b0;
   initial begin
      REQ_OUT = 1'b0;
      CMD_OUT = '1;
   end
   // Wait for idle, pulse the request, take the answer a cycle after done
   task automatic xfer(input logic w, input logic [7:0] c, s, input logic [15:0] d,
                       output pmbsm_pkg::pmbsm_rsp_t rsp);
      int n;
      n = 0;
      do begin
         @(posedge LINK_CLK_IN);
         #1;
         n++;
      end while (BUSY_IN !== 1'b0 && n < 40);
      if (n >= 40) timed_out = 1'b1;
      REQ_OUT = 1'b1;
      CMD_OUT = {w, c, s, d};
      @(posedge LINK_CLK_IN);
      #1;
      REQ_OUT = 1'b0;
      CMD_OUT = ~CMD_OUT; // Released lines lose the old value
      n = 0;
      do begin
         @(posedge LINK_CLK_IN);
         #1;
         n++;
      end while (DONE_IN !== 1'b1 && n < 40);
      @(posedge LINK_CLK_IN);
      #1;
      rsp = RSP_IN;
      if (n >= 40) timed_out = 1'b1;
   endtask
endmodule

// [test_pmbus_status_mask_and_rail_timing.sv]
// Testbench for the status, mask, format and rail timing block
`timescale 1ns/1ps
module test_pmbus_status_mask_and_rail_timing;
   logic                       clk = 0, lclk = 0, rst = 1, en = 0, req, busy, done, pg, al, aoe;
   logic                       mon = 0, mpg = 0;
   logic [3:0]                 slow = 0;
   logic [39:0]                mfr = 0;
   pmbsm_pkg::pmbsm_std_stat_t std = '0;
   pmbsm_pkg::pmbsm_cmd_t      cmd;
   pmbsm_pkg::pmbsm_rsp_t      rsp, r;
   int                         err_total = 0, n_checks = 0;
   logic [7:0] sels [12] = '{8'h7a, 8'h7b, 8'h7d, 8'h7e, 8'h81, 8'h82,
                             8'he0, 8'he1, 8'he2, 8'he3, 8'he4, 8'he5};
   logic [7:0] bad [8] = '{8'h41, 8'h45, 8'h47, 8'h4c, 8'h50, 8'h63, 8'h80, 8'h1b};
   // Core and link clocks
   initial forever #10 clk = ~clk;
   initial forever #15 lclk = ~lclk;
   pmbsm_core #(.MS_CYCLES(5), .FAN_FAULT_CYCLES(20)) pmbsm_core_inst (.CLK_IN(clk), .RST_IN(rst),
      .LINK_CLK_IN(lclk), .LNK_REQ_IN(req), .LNK_CMD_IN(cmd), .LNK_BUSY_OUT(busy), .LNK_DONE_OUT(done),
      .LNK_RSP_OUT(rsp), .STD_STATUS_IN(std), .MFR_STATUS_IN(mfr), .RAIL_EN_IN(en),
      .RAIL_MON_PRESENT_IN(mon), .RAIL_MON_PG_IN(mpg), .RAIL_PG_OUT(pg), .FAN_SLOW_IN(slow),
      .ALERT_OUT(al), .ALERT_OE_OUT(aoe));
   pmbsm_host pmbsm_host_inst (.LINK_CLK_IN(lclk), .BUSY_IN(busy), .DONE_IN(done), .RSP_IN(rsp),
      .REQ_OUT(req), .CMD_OUT(cmd));
   task wrap_up;
      if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [16:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task x(input logic w, input logic [7:0] c, s, input logic [15:0] d);
      pmbsm_host_inst.xfer(w, c, s, d, r);
      if (pmbsm_host_inst.timed_out) begin
         err_total++;
         wrap_up;
      end
   endtask
   task rd(input logic [7:0] c, s, input logic [16:0] e);
      x(1'b0, c, s, 16'h0000);
      chk(r, e);
   endtask
   // Format byte: fixed mode, writable exponent, restore and store
   task t_fmt;
      rd(8'h20, 8'h00, {12'h000, pmbsm_pkg::DEF_VOUT_EXP});
      x(1'b1, 8'h20, 8'h00, 16'hff0b);
      x(1'b1, 8'h12, 8'h00, 16'h0000);
      rd(8'h20, 8'h00, {12'h000, pmbsm_pkg::DEF_VOUT_EXP});
      x(1'b1, 8'h20, 8'h00, 16'h00ff);
      rd(8'h20, 8'h00, 17'h0001f);
      x(1'b1, 8'h11, 8'h00, 16'h0000);
      x(1'b1, 8'h20, 8'h00, 16'h0003);
      x(1'b1, 8'h12, 8'h00, 16'h0000);
      rd(8'h20, 8'h00, 17'h0001f);
      x(1'b1, 8'h38, 8'h00, 16'h0005);
      rd(8'h38, 8'h00, 17'h00005);
   endtask
   // Retired, replaced and misaddressed commands are refused
   task t_nack;
      foreach (bad[i]) begin
         x(1'b0, bad[i], 8'h00, 16'h0000);
         chk(r[16], 1'b1);
      end
      x(1'b1, 8'h81, 8'h00, 16'h0000);
      chk(r[16], 1'b1);
   endtask
   // One mask byte per selector, then masking of the alert line
   task t_mask;
      foreach (sels[i]) x(1'b1, 8'h1b, sels[i], {8'ha5, 8'h30 + 8'(i)});
      foreach (sels[i]) rd(8'h1b, sels[i], {9'h000, 8'h30 + 8'(i)});
      x(1'b1, 8'h1b, 8'h7a, 16'h0001);
      std.vout = 8'h01;
      cyc(4);
      chk(aoe, 1'b0);
      x(1'b1, 8'h1b, 8'h7a, 16'h0000);
      chk(aoe, 1'b1);
      std.vout = 8'h00;
      mfr[33] = 1'b1;
      cyc(4);
      chk(aoe, 1'b0);
      x(1'b1, 8'h1b, 8'he4, 16'h0000);
      chk(aoe, 1'b1);
      mfr = '0;
   endtask
   // Unmonitored rail power-good timing, 5 cycles per ms here
   task t_rail;
      x(1'b1, 8'h62, 8'h00, 16'h0004);
      en = 1'b1;
      cyc(14);
      chk(pg, 1'b0);
      cyc(16);
      chk(pg, 1'b1);
      en = 1'b0;
      cyc(7);
      chk(pg, 1'b0);
      x(1'b1, 8'h66, 8'h00, 16'h0003);
      en = 1'b1;
      cyc(30);
      en = 1'b0;
      cyc(8);
      chk(pg, 1'b1);
      cyc(14);
      chk(pg, 1'b0);
      // Monitored rail follows the monitor's power-good while enabled, not the timers
      mon = 1'b1;
      mpg = 1'b1;
      cyc(4);
      chk(pg, 1'b0);
      en = 1'b1;
      cyc(6);
      chk(pg, 1'b1);
      mpg = 1'b0;
      cyc(4);
      chk(pg, 1'b0);
      en = 1'b0;
      cyc(20);
      mon = 1'b0;
   endtask
   // Fan faults need an unbroken slow spell
   task t_fan;
      slow = 4'b1001;
      cyc(15);
      slow = 4'b0000;
      rd(8'h81, 8'h00, 17'h00000);
      slow = 4'b1001;
      cyc(30);
      rd(8'h81, 8'h00, 17'h00080);
      rd(8'h82, 8'h00, 17'h00040);
      chk(aoe, 1'b1);
      chk(al, 1'b0);
      slow = 4'b0000;
   endtask
   // Main sequence
   initial begin
      cyc(4);
      rst = 1'b0;
      repeat (5) @(posedge lclk);
      t_fmt;
      t_nack;
      t_mask;
      t_rail;
      t_fan;
      wrap_up;
   end
endmodule
